// ### rtl/flash_erase_pkg.sv
// Constants shared by the serial erase sequencer and its testbench
package flash_erase_pkg;
    // Serial instruction framing
    localparam int CMD_BITS = 4;
    localparam int INSTR_BITS = 20;
    localparam logic [4:0] BIT_CNT_LAST = 5'h13;
    localparam logic [4:0] ERASE_START_CLK = 5'h04;
    localparam logic [4:0] SHIFT_OUT_FIRST = 5'h0C;
    localparam logic [3:0] CMD_CORE = 4'h0;
    localparam logic [3:0] CMD_SHIFT_LATCH = 4'h2;
    localparam logic [3:0] CMD_TABLE_WRITE = 4'hC;

    // Core instruction decode
    localparam logic [7:0] OP_MOVLW = 8'h0E;
    localparam logic [7:0] OP_MOVWF = 8'h6E;
    localparam logic [7:0] OP_MOVF_W = 8'h50;
    localparam logic [3:0] OP_BSF = 4'h8;
    localparam logic [3:0] OP_BCF = 4'h9;
    localparam logic [15:0] OP_NOP = 16'h0000;
    localparam logic [7:0] SFR_CONTROL = 8'hA6;
    localparam logic [7:0] SFR_LATCH = 8'hF5;
    localparam logic [7:0] SFR_PTR_LOW = 8'hF6;
    localparam logic [7:0] SFR_PTR_HIGH = 8'hF7;
    localparam logic [7:0] SFR_PTR_UPPER = 8'hF8;

    // Write-control register bit positions
    localparam int BIT_PROG_SEL = 7;
    localparam int BIT_CFG_SEL = 6;
    localparam int BIT_ERASE_SEL = 4;
    localparam int BIT_WRITE_ENABLE_BIT = 2;
    localparam int BIT_WR = 1;

    // Program memory geometry
    localparam int PTR_W = 22;
    localparam int ROW_SHIFT = 6;
    localparam int BLOCK_SHIFT = 14;
    localparam int NUM_BLOCKS = 4;
    localparam logic [21:0] BULK_UPPER_ADDR = 22'h3C_0005;
    localparam logic [21:0] BULK_LOWER_ADDR = 22'h3C_0004;

    // Erase durations
    localparam int CLK_MHZ = 50;
    localparam int ROW_ERASE_US = 1000;
    localparam int BULK_ERASE_US = 5000;

    // Wishbone register byte offsets and status bit positions
    localparam logic [3:0] REG_PROTECT = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_POINTER = 4'h8;
    localparam logic [3:0] REG_BULK = 4'hC;
    localparam int STAT_ROW_BUSY = 8;
    localparam int STAT_BULK_BUSY = 9;

    typedef enum logic {SEQ_RUN, SEQ_BULK_WAIT} seq_e;
endpackage

// ### rtl/level_sync.sv
// Two flip-flop synchroniser for pin levels
`timescale 1ns/100ps
`default_nettype none
module level_sync #(
    parameter int W = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;

    // First stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= async_i;
            stage2 <= stage1;
        end
    end

    assign sync_o = stage2;
endmodule
`default_nettype wire

// ### rtl/erase_timer.sv
// Self-timed erase duration counter
`timescale 1ns/100ps
`default_nettype none
module erase_timer #(
    parameter int unsigned CYCLES = 1000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    output logic busy_o,
    output logic done_o
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] ONE = CW'(1);
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic done;
    logic next_done;

    // Load on start, count down, pulse done in the first cycle at a count of zero
    always_comb begin
        next_count = count;
        next_done = 1'b0;
        if (count != '0) begin
            next_count = count - ONE;
            next_done = (count == ONE);
        end else if (start_i) begin
            next_count = CW'(CYCLES);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= '0;
            done <= 1'b0;
        end else begin
            count <= next_count;
            done <= next_done;
        end
    end

    assign busy_o = (count != '0);
    assign done_o = done;
endmodule
`default_nettype wire

// ### rtl/serial_flash_erase_sequencer.sv
// Serial programming port erase sequencer with Wishbone status access
// What this block does
// - Bulk erase behaves identically whichever programming voltage is used.
// - Row erase of 64 bytes only when block is unprotected.
// - Rows are fixed, aligned from address zero upward.
// - Erased row is the one holding the table pointer.
// - Row erase starts on fourth clock of second NOP.
// - Hardware clears write-start when row erase finishes.
// - Write-start acts only when write-enable was already set.
// - 4-bit command plus 16-bit operand, LSB first, latched falling.
// - Bulk erase starts fourth falling clock after NOP; decoding pauses.
// - Control bits: 7 program, 6 config, 4 erase, 2 enable, 1 start.
// - Command 0000 executes operand; 1100 table-writes without pointer change.
`timescale 1ns/100ps
`default_nettype none
module serial_flash_erase_sequencer #(
    parameter int unsigned ROW_ERASE_CYCLES =
        flash_erase_pkg::ROW_ERASE_US * flash_erase_pkg::CLK_MHZ,
    parameter int unsigned BULK_ERASE_CYCLES =
        flash_erase_pkg::BULK_ERASE_US * flash_erase_pkg::CLK_MHZ
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic prog_serial_clock_i,
    input wire logic prog_serial_data_i,
    output logic prog_serial_data_o,
    output logic prog_serial_data_oe_o,
    output logic row_erase_start_o,
    output logic [flash_erase_pkg::PTR_W-1:0] row_erase_addr_o,
    output logic bulk_erase_start_o,
    output logic [15:0] bulk_erase_code_o,
    output logic erase_busy_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    import flash_erase_pkg::*;
    logic clk_s, data_s, clk_d, fall, rise;
    seq_e state, next_state;
    logic [4:0] bit_cnt, next_bit_cnt;
    logic [INSTR_BITS-1:0] shreg, next_shreg;
    logic [3:0] cur_cmd, next_cur_cmd;
    logic [7:0] wreg, next_wreg, ctrl, next_ctrl, latch, next_latch;
    logic [PTR_W-1:0] ptr, next_ptr, row_addr, next_row_addr;
    logic [7:0] bulk_hi, next_bulk_hi, bulk_lo, next_bulk_lo;
    logic bulk_ready, next_bulk_ready, bulk_nop, next_bulk_nop;
    logic [1:0] wr_nops, next_wr_nops;
    logic row_start, next_row_start, bulk_start, next_bulk_start;
    logic pin_out, next_pin_out, pin_oe, next_pin_oe;
    logic [2*NUM_BLOCKS-1:0] protect, next_protect;
    logic ack, next_ack;
    logic [31:0] rdata, next_rdata;
    logic row_busy, row_done, bulk_busy, bulk_done, row_prot;
    logic [1:0] blk;
    // Pin levels pass two flops before any decoding
    level_sync #(.W(2)) u_pin_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({prog_serial_clock_i, prog_serial_data_i}),
        .sync_o({clk_s, data_s})
    );
    // Self-timed erase durations
    erase_timer #(.CYCLES(ROW_ERASE_CYCLES)) u_row_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(row_start),
        .busy_o(row_busy),
        .done_o(row_done)
    );
    erase_timer #(.CYCLES(BULK_ERASE_CYCLES)) u_bulk_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(bulk_start),
        .busy_o(bulk_busy),
        .done_o(bulk_done)
    );
    // Serial clock edges seen from the synchronised level
    assign fall = clk_d & ~clk_s;
    assign rise = ~clk_d & clk_s;
    // Row protection from code and write protect masks per block
    assign blk = ptr[BLOCK_SHIFT+1:BLOCK_SHIFT];
    assign row_prot = protect[blk] | protect[NUM_BLOCKS + 32'(blk)];
    // Serial decode, core emulation and erase launch
    always_comb begin
        logic [INSTR_BITS-1:0] sh;
        logic [15:0] opnd;
        logic [7:0] wbyte;
        sh = {data_s, shreg[INSTR_BITS-1:1]};
        opnd = sh[INSTR_BITS-1:CMD_BITS];
        wbyte = ptr[0] ? opnd[15:8] : opnd[7:0];
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_cur_cmd = cur_cmd;
        next_wreg = wreg;
        next_ctrl = ctrl;
        next_latch = latch;
        next_ptr = ptr;
        next_bulk_hi = bulk_hi;
        next_bulk_lo = bulk_lo;
        next_bulk_ready = bulk_ready;
        next_bulk_nop = bulk_nop;
        next_wr_nops = wr_nops;
        next_row_start = 1'b0;
        next_bulk_start = 1'b0;
        next_row_addr = row_addr;
        next_pin_out = pin_out;
        next_pin_oe = pin_oe;
        next_protect = protect;
        // Hardware clears write-start when the row erase ends
        if (row_done) begin
            next_ctrl[BIT_WR] = 1'b0;
        end
        if (state == SEQ_BULK_WAIT) begin
            // Bits arriving now are dropped
            if (bulk_done) begin
                next_state = SEQ_RUN;
                next_bit_cnt = '0;
                next_shreg = '0;
                next_protect = '0;
            end
        end else if (fall) begin
            next_shreg = sh;
            next_bit_cnt = bit_cnt + 5'h01;
            if (next_bit_cnt == ERASE_START_CLK) begin
                next_cur_cmd = sh[INSTR_BITS-1:INSTR_BITS-CMD_BITS];
                // Bulk erase on fourth clock after the NOP
                if (bulk_nop) begin
                    next_bulk_nop = 1'b0;
                    next_bulk_ready = 1'b0;
                    next_bulk_start = 1'b1;
                    next_state = SEQ_BULK_WAIT;
                end
                // Row erase on fourth clock of the second NOP
                if (ctrl[BIT_WR] && wr_nops == 2'h1 &&
                        next_cur_cmd == CMD_CORE) begin
                    next_wr_nops = 2'h2;
                    if (ctrl[BIT_ERASE_SEL] && ctrl[BIT_PROG_SEL] &&
                            !ctrl[BIT_CFG_SEL] && !row_prot) begin
                        next_row_start = 1'b1;
                        next_row_addr = {ptr[PTR_W-1:ROW_SHIFT],
                            ROW_SHIFT'(0)};
                    end else begin
                        next_ctrl[BIT_WR] = 1'b0;
                    end
                end
            end
            if (bit_cnt == BIT_CNT_LAST) begin
                next_bit_cnt = '0;
                next_pin_oe = 1'b0;
                if (cur_cmd == CMD_CORE) begin
                    if (opnd == OP_NOP) begin
                        if (ctrl[BIT_WR] && wr_nops == 2'h0) begin
                            next_wr_nops = 2'h1;
                        end
                        if (bulk_ready) begin
                            next_bulk_nop = 1'b1;
                        end
                    end else if (opnd[15:8] == OP_MOVLW) begin
                        next_wreg = opnd[7:0];
                    end else if (opnd[15:8] == OP_MOVF_W) begin
                        if (opnd[7:0] == SFR_CONTROL) begin
                            next_wreg = ctrl;
                        end else if (opnd[7:0] == SFR_LATCH) begin
                            next_wreg = latch;
                        end
                    end else if (opnd[15:8] == OP_MOVWF) begin
                        case (opnd[7:0])
                            SFR_PTR_UPPER: begin
                                next_ptr[PTR_W-1:16] = wreg[PTR_W-17:0];
                            end
                            SFR_PTR_HIGH: next_ptr[15:8] = wreg;
                            SFR_PTR_LOW: next_ptr[7:0] = wreg;
                            SFR_LATCH: next_latch = wreg;
                            default: next_latch = latch;
                        endcase
                    end else if (opnd[7:0] == SFR_CONTROL &&
                            (opnd[15:12] == OP_BSF ||
                             opnd[15:12] == OP_BCF)) begin
                        // Bit set or clear of the write-control register
                        if (opnd[11:9] == 3'(BIT_WR)) begin
                            if (opnd[15:12] == OP_BSF && ctrl[BIT_WRITE_ENABLE_BIT] &&
                                    !ctrl[BIT_WR]) begin
                                next_ctrl[BIT_WR] = 1'b1;
                                next_wr_nops = 2'h0;
                            end
                        end else begin
                            next_ctrl[opnd[11:9]] = (opnd[15:12] == OP_BSF);
                        end
                    end
                end else if (cur_cmd == CMD_TABLE_WRITE) begin
                    // Pointer is left unchanged
                    if (ptr == BULK_UPPER_ADDR) begin
                        next_bulk_hi = wbyte;
                    end else if (ptr == BULK_LOWER_ADDR) begin
                        next_bulk_lo = wbyte;
                        next_bulk_ready = 1'b1;
                    end
                end
            end
        end else if (rise && cur_cmd == CMD_SHIFT_LATCH &&
                bit_cnt >= SHIFT_OUT_FIRST) begin
            // Latch driven LSB first over the last eight clocks
            next_pin_oe = 1'b1;
            next_pin_out = latch[3'(bit_cnt - SHIFT_OUT_FIRST)];
        end
        // Software writes the protect masks at the acknowledged edge
        if (wb_cyc_i && wb_stb_i && wb_we_i && ack &&
                wb_adr_i == REG_PROTECT && wb_sel_i[0]) begin
            next_protect = wb_dat_i[2*NUM_BLOCKS-1:0];
        end
    end

    // Wishbone slave: one wait state, unmapped reads return zero
    always_comb begin
        next_ack = wb_cyc_i & wb_stb_i & ~ack;
        next_rdata = '0;
        case (wb_adr_i)
            REG_PROTECT: next_rdata[2*NUM_BLOCKS-1:0] = protect;
            REG_STATUS: begin
                next_rdata[7:0] = ctrl;
                next_rdata[STAT_ROW_BUSY] = row_busy;
                next_rdata[STAT_BULK_BUSY] = (state == SEQ_BULK_WAIT);
            end
            REG_POINTER: next_rdata[PTR_W-1:0] = ptr;
            REG_BULK: next_rdata[15:0] = {bulk_hi, bulk_lo};
            default: next_rdata = '0;
        endcase
    end

    // State registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_d <= 1'b0;
            state <= SEQ_RUN;
            bit_cnt <= '0;
            shreg <= '0;
            cur_cmd <= '0;
            wreg <= '0;
            ctrl <= '0;
            latch <= '0;
            ptr <= '0;
            bulk_hi <= '0;
            bulk_lo <= '0;
            bulk_ready <= 1'b0;
            bulk_nop <= 1'b0;
            wr_nops <= '0;
            row_start <= 1'b0;
            bulk_start <= 1'b0;
            row_addr <= '0;
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
            protect <= '0;
            ack <= 1'b0;
            rdata <= '0;
        end else begin
            clk_d <= clk_s;
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            cur_cmd <= next_cur_cmd;
            wreg <= next_wreg;
            ctrl <= next_ctrl;
            latch <= next_latch;
            ptr <= next_ptr;
            bulk_hi <= next_bulk_hi;
            bulk_lo <= next_bulk_lo;
            bulk_ready <= next_bulk_ready;
            bulk_nop <= next_bulk_nop;
            wr_nops <= next_wr_nops;
            row_start <= next_row_start;
            bulk_start <= next_bulk_start;
            row_addr <= next_row_addr;
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            protect <= next_protect;
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end
    // Outputs
    assign prog_serial_data_o = pin_out;
    assign prog_serial_data_oe_o = pin_oe;
    assign row_erase_start_o = row_start;
    assign row_erase_addr_o = row_addr;
    assign bulk_erase_start_o = bulk_start;
    assign bulk_erase_code_o = {bulk_hi, bulk_lo};
    assign erase_busy_o = row_busy | (state == SEQ_BULK_WAIT);
    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;

    // Checks on the erase sequencing
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_row_launch;
        row_start ##1 row_busy;
    endsequence

    a_wr_needs_write_enable_bit: assert property ($rose(ctrl[BIT_WR]) |->
        $past(ctrl[BIT_WRITE_ENABLE_BIT])) else $error("start without enable");
    a_row_aligned: assert property (row_start |->
        row_addr[ROW_SHIFT-1:0] == '0) else $error("row unaligned");
    a_row_from_ptr: assert property (row_start |->
        row_addr[PTR_W-1:ROW_SHIFT] == ptr[PTR_W-1:ROW_SHIFT])
        else $error("row not at pointer");
    a_row_unprotected: assert property (row_start |-> !row_prot)
        else $error("protected row erased");
    a_row_fourth_clk: assert property (row_start |->
        bit_cnt == ERASE_START_CLK && cur_cmd == CMD_CORE &&
        $past(wr_nops) == 2'h1) else $error("row start misplaced");
    a_wr_held_busy: assert property (s_row_launch |-> ctrl[BIT_WR])
        else $error("start bit dropped early");
    a_wr_clears: assert property (row_done |=> !ctrl[BIT_WR])
        else $error("start bit not cleared");
    a_bulk_fourth_clk: assert property (bulk_start |->
        bit_cnt == ERASE_START_CLK && state == SEQ_BULK_WAIT &&
        $past(bulk_nop)) else $error("bulk start misplaced");
    a_bulk_ignores: assert property (state == SEQ_BULK_WAIT && !bulk_done
        |=> bit_cnt == $past(bit_cnt)) else $error("bits in erase");
    a_bulk_timed: assert property (bulk_start |=> bulk_busy)
        else $error("bulk timer idle");
endmodule
`default_nettype wire

// ### sim/prog_model.sv
// Programmer model that clocks instructions into the serial port
`timescale 1ns/100ps
`default_nettype none
module prog_model (
    input wire logic clk_i,
    input wire logic line_i,
    output logic sclk_o,
    output logic sdat_o
);
    // Serial clock idles low between frames
    initial begin
        sclk_o = 1'b0;
        sdat_o = 1'b0;
    end

    // One bit: driven with the rise, sampled just before the fall
    task automatic bit_out(input logic b, output logic seen);
        @(posedge clk_i);
        sclk_o <= 1'b1;
        sdat_o <= b;
        repeat (4) @(posedge clk_i);
        seen = line_i;
        sclk_o <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    // Command first, then operand, least significant bit first
    task automatic send(input logic [3:0] cmd, input logic [15:0] op,
                        output logic [7:0] got);
        logic [19:0] f;
        logic s;
        f = {op, cmd};
        got = 8'h00;
        for (int i = 0; i < 20; i++) begin
            bit_out(f[i], s);
            if (i >= 12) got[i-12] = s; // Released bits alternate
        end
        // One idle edge so the decode of the last bit has landed
        @(posedge clk_i);
    endtask

    // Core instruction; a NOP leaves the data line low after it
    task automatic core(input logic [15:0] op);
        logic [7:0] g;
        send(4'h0, op, g);
    endtask
endmodule
`default_nettype wire

// ### sim/serial_flash_erase_sequencer_tb_top.sv
// Bench for the serial erase sequencer and its status registers
`timescale 1ns/100ps
`default_nettype none
module serial_flash_erase_sequencer_tb_top;
    import flash_erase_pkg::*;
    localparam int LIMIT = 60000;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sclk, sdat, line, dev_d, dev_oe, row_start, bulk_start, busy, ack;
    logic [21:0] row_addr;
    logic [21:0] row_seen = 22'h00_0000;
    logic [15:0] bulk_code;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] dat_w = 32'h0000_0000;
    logic [31:0] dat_r;
    int err_count = 0, n_compared = 0, cycles = 0, row_n = 0, bulk_n = 0;
    logic [3:0] ra [5] = '{REG_PROTECT, REG_STATUS, REG_POINTER, REG_BULK,
                           4'h2};
    logic [15:0] rs [7] = '{16'h8EA6, 16'h9CA6, 16'h84A6, 16'h88A6,
                            16'h0000, 16'h82A6, 16'h0000};
    logic [15:0] su [5] = '{16'h88A6, 16'h94A6, 16'h8CA6, 16'h88A6, 16'h88A6};
    logic [7:0] pr [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h10};
    logic [7:0] ec [5] = '{8'h94, 8'h90, 8'hD4, 8'h94, 8'h94};
    logic [31:0] pn [5] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0};

    // Clock
    initial forever #10 clk_i = ~clk_i;

    // Shared data wire
    assign line = dev_oe ? dev_d : sdat;

    serial_flash_erase_sequencer #(
        .ROW_ERASE_CYCLES(2000),
        .BULK_ERASE_CYCLES(400)
    ) i_serial_flash_erase_sequencer (
        .clk_i(clk_i), .rst_i(rst_i),
        .prog_serial_clock_i(sclk), .prog_serial_data_i(line),
        .prog_serial_data_o(dev_d), .prog_serial_data_oe_o(dev_oe),
        .row_erase_start_o(row_start), .row_erase_addr_o(row_addr),
        .bulk_erase_start_o(bulk_start), .bulk_erase_code_o(bulk_code),
        .erase_busy_o(busy), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
        .wb_ack_o(ack)
    );

    prog_model i_prog_model (
        .clk_i(clk_i), .line_i(line), .sclk_o(sclk), .sdat_o(sdat)
    );

    task automatic final_report();
        if (err_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] got,
                         input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Classic Wishbone cycle held until ack is sampled
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        dat_w <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic core(input logic [15:0] op);
        i_prog_model.core(op);
    endtask

    // Load the three pointer bytes through W
    task automatic ptr(input logic [21:0] a);
        core({8'h0E, 2'h0, a[21:16]});
        core(16'h6EF8);
        core({8'h0E, a[15:8]});
        core(16'h6EF7);
        core({8'h0E, a[7:0]});
        core(16'h6EF6);
    endtask

    // Control register copied to the latch and shifted out
    task automatic rdctl(output logic [7:0] c);
        core(16'h50A6);
        core(16'h6EF5);
        core(16'h0000);
        i_prog_model.send(CMD_SHIFT_LATCH, 16'hAAAA, c);
    endtask

    // Pulse counters and hang limit
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (row_start === 1'b1) begin
            row_n <= row_n + 1;
            row_seen <= row_addr;
        end
        if (bulk_start === 1'b1) bulk_n <= bulk_n + 1;
        if (cycles == LIMIT) begin
            err_count = err_count + 1;
            final_report();
        end
    end

    initial begin
        logic [31:0] q;
        logic [7:0] c;
        int r0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        // Cleared registers; an unmapped place reads zero
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, ra[i], 32'h0000_0000, q);
            check("register", q, 32'h0000_0000);
        end
        wb(1'b1, 4'h2, 32'hFFFF_FFFF, q);
        check("busy", {31'h0, busy}, 32'h0000_0000);
        // Row erase: good setup, then refusals for cleared enable, config select, code and write protect
        ptr(22'h00_1273);
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, REG_PROTECT, {24'h00_0000, pr[i]}, q);
            for (int j = 0; j < 7; j++) core(j == 4 ? su[i] : rs[j]);
            r0 = row_n;
            core(16'h0000);
            check("row_pulses", row_n - r0, pn[i]);
            c = 8'hFF;
            for (int k = 0; k < 10 && c[BIT_WR] !== 1'b0; k++) rdctl(c);
            check("wr_bit", {31'h0, c[BIT_WR]}, 32'h0000_0000);
            wb(1'b0, REG_STATUS, 32'h0000_0000, q);
            check("control", q, {24'h00_0000, ec[i]});
        end
        check("row_addr", row_seen, 22'h00_1240);
        // Whole-device erase; bits sent during the wait are dropped
        wb(1'b1, REG_PROTECT, 32'h0000_00FF, q);
        ptr(22'h3C_0005);
        i_prog_model.send(CMD_TABLE_WRITE, 16'h0F0F, c);
        ptr(22'h3C_0004);
        i_prog_model.send(CMD_TABLE_WRITE, 16'h8F8F, c);
        check("bulk_code", bulk_code, 16'h0F8F);
        core(16'h0000);
        check("bulk_early", bulk_n, 32'h0000_0000);
        core(16'h0000);
        core(16'h0000);
        check("bulk_pulses", bulk_n, 32'h0000_0001);
        for (int k = 0; k < 1000 && busy === 1'b1; k++) @(posedge clk_i);
        core(16'h6EF6);
        wb(1'b0, REG_POINTER, 32'h0000_0000, q);
        check("pointer_kept", q, 32'h003C_0004);
        core(16'h0E22);
        core(16'h6EF6);
        wb(1'b0, REG_POINTER, 32'h0000_0000, q);
        check("pointer_resumed", q, 32'h003C_0022);
        wb(1'b0, REG_PROTECT, 32'h0000_0000, q);
        check("protect", q, 32'h0000_0000);
        final_report();
    end
endmodule
`default_nettype wire
